// ==== iap_pkg.sv ====
// constants, encodings and register map of the flash programming front end
package iap_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_SETTLE_NS = 1000;
    localparam int OSC_SETTLE_CYC =
        (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 4;

    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [23:0] RD_PAD = 24'h00_0000;
    localparam logic [5:0] IRQ_PAD = 6'h00;
    localparam logic [7:0] SIG_NONE = 8'h00;

    localparam int ST_BUSY_BIT = 2;
    localparam int CF_IAP_EN_BIT = 6;
    localparam int CF_BANK_MSB = 1;
    localparam int CF_BANK_LSB = 0;
    localparam int CM_IRQ_SEL_BIT = 7;
    localparam int AH_TAG_MSB = 7;
    localparam int AH_TAG_LSB = 5;
    localparam logic [2:0] TAG_BLK1 = 3'h7;
    localparam logic [2:0] TAG_LOW8K = 3'h0;
    localparam logic [1:0] BANK_NONE = 2'h0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REJ_BIT = 1;

    localparam logic [7:0] SIG_MFR_ADDR = 8'h30;
    localparam logic [7:0] SIG_DEV_ADDR = 8'h31;

    localparam logic [6:0] CMD_SECT_ERASE = 7'h0b;
    localparam logic [6:0] CMD_VERIFY = 7'h0c;
    localparam logic [6:0] CMD_BLK_ERASE = 7'h0d;
    localparam logic [6:0] CMD_BYTE_PROG = 7'h0e;
    localparam logic [6:0] CMD_READ_SIG = 7'h0a;

    typedef enum logic [1:0] {
        FROM_BLK0 = 2'b00,
        FROM_BLK1 = 2'b01,
        FROM_EXT = 2'b10
    } fetch_src_e;

    typedef enum logic [1:0] {
        OP_PROG = 2'b00,
        OP_SECT_ERASE = 2'b01,
        OP_BLK_ERASE = 2'b10,
        OP_VERIFY = 2'b11
    } flash_op_e;
endpackage

// ==== iap_op_if.sv ====
// request and completion path between mailbox front end and sequencer
`timescale 1ns/10ps
interface iap_op_if;
    logic start;
    iap_pkg::flash_op_e op;
    logic blk;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    modport ctrl (output start, op, blk, addr, wdata,
                  input busy, done, rdata);
    modport seq (input start, op, blk, addr, wdata,
                 output busy, done, rdata);
endinterface

// ==== iap_target_resolve.sv ====
// decides which flash block an accepted request may touch
`timescale 1ns/10ps
module iap_target_resolve (
    input wire logic [1:0] fetch_src, // where the requesting code runs
    input wire logic [7:0] addr_high, // high address mailbox byte
    input wire logic [1:0] bank_sel, // bank-select config bits
    input wire logic ext_access_n, // low: external program execution
    output logic tgt_blk, // 1 selects the secondary block
    output logic legal // request may proceed
);
    wire [2:0] tag = addr_high[iap_pkg::AH_TAG_MSB:iap_pkg::AH_TAG_LSB];
    // overlay puts block 1 over the lowest 8 KByte of block 0
    wire overlay = ext_access_n & (bank_sel != iap_pkg::BANK_NONE);
    wire ext_blk1 = (tag == iap_pkg::TAG_BLK1) |
                    (overlay & (tag == iap_pkg::TAG_LOW8K));
    wire from0 = fetch_src == iap_pkg::FROM_BLK0;
    wire from1 = fetch_src == iap_pkg::FROM_BLK1;
    wire fromx = fetch_src == iap_pkg::FROM_EXT;

    // implicit targets keep code off its own block
    assign tgt_blk = from0 ? 1'b1 :
                     from1 ? 1'b0 :
                     ext_blk1;
    // an unknown fetch source never reaches the array
    assign legal = from0 | from1 | fromx;
endmodule

// ==== iap_op_sequencer.sv ====
// runs one flash operation: oscillator warm-up, array request, completion
`timescale 1ns/10ps
module iap_op_sequencer #(
    parameter int SETTLE_CYC = iap_pkg::OSC_SETTLE_CYC
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic ce, // clock enable
    iap_op_if.seq op, // request from the mailbox
    output logic osc_en, // timing oscillator enable
    output logic fl_req, // array request, held until fl_done
    output logic [1:0] fl_op, // array operation code
    output logic fl_blk, // target block
    output logic [15:0] fl_addr, // target address
    output logic [7:0] fl_wdata, // program data
    input wire logic fl_done, // array finished, one cycle
    input wire logic [7:0] fl_rdata // verify data
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WARM = 2'b01,
        S_RUN = 2'b10
    } seq_state_e;

    localparam logic [iap_pkg::SETTLE_W-1:0] SETTLE_LAST =
        iap_pkg::SETTLE_W'(SETTLE_CYC - 1);
    localparam logic [iap_pkg::SETTLE_W-1:0] CNT_ZERO = '0;

    seq_state_e state_q;
    logic [iap_pkg::SETTLE_W-1:0] cnt_q;
    logic done_q;
    logic [7:0] rdata_q;

    // verify needs no timing reference, so it skips the warm-up
    wire needs_osc = op.op != iap_pkg::OP_VERIFY;
    wire warm_end = cnt_q == SETTLE_LAST;
    wire finish = (state_q == S_RUN) & fl_done;

    assign op.busy = state_q != S_IDLE;
    assign op.done = done_q;
    assign op.rdata = rdata_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q <= CNT_ZERO;
            osc_en <= 1'b0;
            fl_req <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= finish;
            unique case (state_q)
                S_IDLE: begin
                    cnt_q <= CNT_ZERO;
                    if (op.start) begin
                        state_q <= needs_osc ? S_WARM : S_RUN;
                        osc_en <= needs_osc;
                        fl_req <= ~needs_osc;
                    end
                end
                S_WARM: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (warm_end) begin
                        state_q <= S_RUN;
                        fl_req <= 1'b1;
                    end
                end
                S_RUN: begin
                    if (fl_done) begin
                        state_q <= S_IDLE;
                        fl_req <= 1'b0;
                        osc_en <= 1'b0;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fl_op <= 2'b00;
            fl_blk <= 1'b0;
            fl_addr <= 16'h0000;
            fl_wdata <= 8'h00;
            rdata_q <= 8'h00;
        end else if (ce) begin
            if (op.start && state_q == S_IDLE) begin
                fl_op <= op.op;
                fl_blk <= op.blk;
                fl_addr <= op.addr;
                fl_wdata <= op.wdata;
            end
            if (finish) begin
                rdata_q <= fl_rdata;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence s_warm_start;
        op.start && state_q == S_IDLE && needs_osc;
    endsequence
    sequence s_warm_run;
        osc_en && !fl_req;
    endsequence

    AST_WARM_BEFORE_REQ: assert property (
        s_warm_start |=> s_warm_run ##0 cnt_q == CNT_ZERO)
        else $error("array request before oscillator settled");
    AST_WARM_HOLD: assert property (
        state_q == S_WARM |-> s_warm_run)
        else $error("oscillator off or request early during warm-up");
    AST_WARM_END: assert property (
        state_q == S_WARM && warm_end |=> fl_req && osc_en)
        else $error("array request missing after warm-up");
    AST_OSC_OFF_AFTER: assert property (
        finish |=> !osc_en && !op.busy && done_q)
        else $error("oscillator left running after completion");
endmodule

// ==== flash_iap_mailbox_control.sv ====
// mailbox register front end for in-application flash programming
//
// Overview of operation
// - read-signature returns maker byte at 30H, device byte at 31H.
// - one block is programmed while code runs from the other.
// - external code fetch continues while internal blocks reprogram.
// - eight mailbox registers alone control and monitor flash work.
// - in programming mode core and controller run on external clock.
// - timing oscillator runs only while an operation needs it.
// - access pin and bank bits overlay block 1 on lowest 8 KByte.
// - an invisible block is programmable from the other block.
// - code never modifies the block it executes from.
// - requests from the primary block target the secondary block.
// - requests from the secondary block target the primary block.
// - external fetch picks the target from address and bank select.
// - configuration bit 6 enables programming; otherwise commands drop.
// - writing the command byte starts an operation after loading.
// - status bit 2 is busy while an operation runs.
// - command bit 7 signals completion on external interrupt one.
// - commands aimed at a locked block are not carried out.
`timescale 1ns/10ps
module flash_iap_mailbox_control #(
    parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'ha5, // arbitrary value
    parameter int SETTLE_CYC = iap_pkg::OSC_SETTLE_CYC
) (
    input wire logic SYS_CLK, // system clock, 10 MHz
    input wire logic SYS_RST, // synchronous reset, active high
    input wire logic CLK_EN, // clock enable, freezes state when low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb write
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic EXT_ACCESS_N, // external access pin, active low
    input wire logic [1:0] FETCH_SRC, // where requesting code executes
    input wire logic [1:0] BLOCK_LOCK, // security lock per block
    input wire logic EXT_INTERRUPT_ONE_PIN, // external interrupt one pin
    input wire logic FL_DONE, // array operation finished
    input wire logic [7:0] FL_RDATA, // array verify data
    output logic FL_REQ, // array request
    output logic [1:0] FL_OP, // array operation
    output logic FL_BLOCK, // array target block
    output logic [15:0] FL_ADDR, // array address
    output logic [7:0] FL_WDATA, // array program data
    output logic OSC_EN, // timing oscillator enable
    output logic EXT_CLK_SEL, // core and controller on external clock
    output logic [1:0] BLOCK_BUSY, // per block, fetch must avoid it
    output logic EXT_INTERRUPT_ONE_REQ, // interrupt one request to the core
    output logic IRQ // level interrupt from mailbox events
);
    logic [7:0] cfg_q, cmd_q, al_q, ah_q, dt_q;
    logic [1:0] irq_st_q, irq_st_d, irq_mask_q;
    logic start_q, verify_q, route_q, tgt_q;
    iap_pkg::flash_op_e op_q;
    logic [7:0] rd_byte;
    logic tgt_blk, tgt_legal;

    iap_op_if op_bus();

    // apb decode
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE & PREADY;
    wire wr_acc = access & PWRITE;
    wire rd_acc = access & ~PWRITE;
    wire sel_st = PADDR == iap_pkg::OFS_STATUS;
    wire sel_cmd = PADDR == iap_pkg::OFS_CMD;
    wire sel_al = PADDR == iap_pkg::OFS_ADDR_LOW;
    wire sel_ah = PADDR == iap_pkg::OFS_ADDR_HIGH;
    wire sel_dt = PADDR == iap_pkg::OFS_DATA;
    wire sel_cf = PADDR == iap_pkg::OFS_CONFIG;
    wire sel_is = PADDR == iap_pkg::OFS_IRQ_STATUS;
    wire sel_im = PADDR == iap_pkg::OFS_IRQ_MASK;
    wire hit = sel_st | sel_cmd | sel_al | sel_ah | sel_dt | sel_cf |
               sel_is | sel_im;

    // command decode
    wire [6:0] code = PWDATA[6:0];
    wire is_prog = code == iap_pkg::CMD_BYTE_PROG;
    wire is_sect = code == iap_pkg::CMD_SECT_ERASE;
    wire is_blk = code == iap_pkg::CMD_BLK_ERASE;
    wire is_ver = code == iap_pkg::CMD_VERIFY;
    wire is_flash = is_prog | is_sect | is_blk | is_ver;
    wire is_sig = code == iap_pkg::CMD_READ_SIG;
    wire iap_en = cfg_q[iap_pkg::CF_IAP_EN_BIT];
    wire busy_flag = start_q | op_bus.busy;
    wire locked = BLOCK_LOCK[tgt_blk];
    wire cmd_wr = wr_acc & sel_cmd;
    wire accept = cmd_wr & is_flash & iap_en & tgt_legal & ~locked &
                  ~busy_flag;
    wire reject = cmd_wr & is_flash & ~accept;
    wire sig_rd = cmd_wr & is_sig & iap_en & ~busy_flag;
    wire ver_done = op_bus.done & verify_q;
    wire [7:0] sig_byte = (al_q == iap_pkg::SIG_MFR_ADDR) ? MFR_ID :
                          (al_q == iap_pkg::SIG_DEV_ADDR) ? DEV_ID :
                          iap_pkg::SIG_NONE;
    wire iap_pkg::flash_op_e op_sel =
        is_prog ? iap_pkg::OP_PROG :
        is_sect ? iap_pkg::OP_SECT_ERASE :
        is_blk ? iap_pkg::OP_BLK_ERASE : iap_pkg::OP_VERIFY;
    wire [7:0] status_byte = 8'(busy_flag) << iap_pkg::ST_BUSY_BIT;
    wire [1:0] events = (2'(op_bus.done) << iap_pkg::IRQ_DONE_BIT) |
                        (2'(reject) << iap_pkg::IRQ_REJ_BIT);
    // only bits that were returned by the read are cleared, so an event
    // landing between setup and access is kept for the next read
    localparam logic [1:0] IRQ_NONE = iap_pkg::IRQ_RESET;
    wire [1:0] rd_clr = (rd_acc & sel_is) ? PRDATA[1:0] : IRQ_NONE;

    assign irq_st_d = (irq_st_q & ~rd_clr) | events;
    assign rd_byte = sel_st ? status_byte :
                     sel_cmd ? cmd_q :
                     sel_al ? al_q :
                     sel_ah ? ah_q :
                     sel_dt ? dt_q :
                     sel_cf ? cfg_q :
                     sel_is ? {iap_pkg::IRQ_PAD, irq_st_q} :
                     sel_im ? {iap_pkg::IRQ_PAD, irq_mask_q} :
                     iap_pkg::REG_RESET;

    // fetch from the non-target block or from outside goes on meanwhile
    iap_target_resolve u_resolve (
        .fetch_src (FETCH_SRC),
        .addr_high (ah_q),
        .bank_sel (cfg_q[iap_pkg::CF_BANK_MSB:iap_pkg::CF_BANK_LSB]),
        .ext_access_n (EXT_ACCESS_N),
        .tgt_blk (tgt_blk),
        .legal (tgt_legal)
    );

    assign op_bus.start = start_q;
    assign op_bus.op = op_q;
    assign op_bus.blk = tgt_q;
    assign op_bus.addr = {ah_q, al_q};
    assign op_bus.wdata = dt_q;

    iap_op_sequencer #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_seq (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .ce (CLK_EN),
        .op (op_bus.seq),
        .osc_en (OSC_EN),
        .fl_req (FL_REQ),
        .fl_op (FL_OP),
        .fl_blk (FL_BLOCK),
        .fl_addr (FL_ADDR),
        .fl_wdata (FL_WDATA),
        .fl_done (FL_DONE),
        .fl_rdata (FL_RDATA)
    );

    // zero-wait slave: read data and ready are prepared in the setup cycle
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CLK_EN) begin
            PREADY <= setup;
            PSLVERR <= setup & ~hit;
            if (setup) begin
                PRDATA <= {iap_pkg::RD_PAD, rd_byte};
            end
        end
    end

    // mailbox registers written by software
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cfg_q <= iap_pkg::REG_RESET;
            cmd_q <= iap_pkg::REG_RESET;
            al_q <= iap_pkg::REG_RESET;
            ah_q <= iap_pkg::REG_RESET;
            irq_mask_q <= iap_pkg::IRQ_RESET;
        end else if (CLK_EN && wr_acc) begin
            if (sel_cf) cfg_q <= PWDATA[7:0];
            if (sel_cmd) cmd_q <= PWDATA[7:0];
            if (sel_al) al_q <= PWDATA[7:0];
            if (sel_ah) ah_q <= PWDATA[7:0];
            if (sel_im) irq_mask_q <= PWDATA[1:0];
        end
    end

    // data mailbox also carries signature and verify results back
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            dt_q <= iap_pkg::REG_RESET;
        end else if (CLK_EN) begin
            if (sig_rd) begin
                dt_q <= sig_byte;
            end else if (ver_done) begin
                dt_q <= op_bus.rdata;
            end else if (wr_acc && sel_dt) begin
                dt_q <= PWDATA[7:0];
            end
        end
    end

    // operation launch and completion routing
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            start_q <= 1'b0;
            op_q <= iap_pkg::OP_PROG;
            verify_q <= 1'b0;
            tgt_q <= 1'b0;
            route_q <= 1'b0;
        end else if (CLK_EN) begin
            start_q <= accept;
            if (accept) begin
                op_q <= op_sel;
                verify_q <= is_ver;
                tgt_q <= tgt_blk;
                route_q <= PWDATA[iap_pkg::CM_IRQ_SEL_BIT];
            end else if (op_bus.done) begin
                route_q <= 1'b0;
            end
        end
    end

    // status, interrupts and system-facing levels
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            irq_st_q <= iap_pkg::IRQ_RESET;
            IRQ <= 1'b0;
            EXT_INTERRUPT_ONE_REQ <= 1'b0;
            EXT_CLK_SEL <= 1'b0;
            BLOCK_BUSY <= 2'b00;
        end else if (CLK_EN) begin
            irq_st_q <= irq_st_d;
            IRQ <= |(irq_st_d & irq_mask_q);
            // while routed, the pin is no longer an interrupt source
            EXT_INTERRUPT_ONE_REQ <= route_q ? op_bus.done : EXT_INTERRUPT_ONE_PIN;
            EXT_CLK_SEL <= iap_en;
            BLOCK_BUSY <= {busy_flag & tgt_q,
                           busy_flag & ~tgt_q};
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST || !CLK_EN);

    sequence s_op_done;
        op_bus.done && route_q;
    endsequence

    AST_SIG_MFR: assert property (
        sig_rd && al_q == iap_pkg::SIG_MFR_ADDR |=> dt_q == MFR_ID)
        else $error("maker signature not returned");
    AST_SIG_DEV: assert property (
        sig_rd && al_q == iap_pkg::SIG_DEV_ADDR |=> dt_q == DEV_ID)
        else $error("device signature not returned");
    AST_FROM_BLK0: assert property (
        accept && FETCH_SRC == iap_pkg::FROM_BLK0 |=> op_bus.blk == 1'b1)
        else $error("block 0 code did not target block 1");
    AST_FROM_BLK1: assert property (
        accept && FETCH_SRC == iap_pkg::FROM_BLK1 |=> op_bus.blk == 1'b0)
        else $error("block 1 code did not target block 0");
    AST_EXT_TAG: assert property (
        accept && FETCH_SRC == iap_pkg::FROM_EXT &&
        ah_q[iap_pkg::AH_TAG_MSB:iap_pkg::AH_TAG_LSB] == iap_pkg::TAG_BLK1
        |=> op_bus.blk)
        else $error("external request missed block 1");
    AST_IAP_OFF: assert property (
        cmd_wr && !iap_en |=> (!start_q && !OSC_EN) [*2])
        else $error("command acted on with programming disabled");
    AST_LOCKED: assert property (
        cmd_wr && is_flash && locked |=> !start_q ##1 !op_bus.busy)
        else $error("locked block was operated on");
    AST_BUSY: assert property (
        accept |=> status_byte[iap_pkg::ST_BUSY_BIT] ##1 op_bus.busy)
        else $error("busy flag not raised");
    AST_REJECT_QUIET: assert property (
        reject && !busy_flag |=> !busy_flag && irq_st_q[iap_pkg::IRQ_REJ_BIT])
        else $error("rejected command changed busy or was not flagged");
    AST_EXT_INTERRUPT_ONE_ROUTE: assert property (
        s_op_done |=> EXT_INTERRUPT_ONE_REQ ##1 !EXT_INTERRUPT_ONE_REQ)
        else $error("completion not signalled on interrupt one");
    AST_CLK_SRC: assert property (
        $rose(iap_en) |=> EXT_CLK_SEL)
        else $error("external clock not selected in programming mode");
    AST_BLOCK_BUSY: assert property (
        BLOCK_BUSY[0] |-> !BLOCK_BUSY[1])
        else $error("both blocks marked busy at once");
endmodule

// ==== flash_array_model.sv ====
// behavioural flash array answering the sequencer's requests
`timescale 1ns/10ps
module flash_array_model #(
    parameter int LAT = 3 // completion comes LAT+1 cycles after the request
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic req, // array request
    input wire logic [1:0] op, // array operation
    input wire logic blk, // target block
    input wire logic [15:0] addr, // target address
    input wire logic [7:0] wdata, // program data
    input wire logic osc_en, // timing oscillator enable
    output logic done, // completion pulse
    output logic [7:0] rdata, // verify data
    output logic terr // array worked without its oscillator
);
    logic [7:0] mem [2][256];
    int cnt;
    always_ff @(posedge clk) begin
        done <= 1'b0;
        // stale data is inverted so it never passes for a fresh answer
        rdata <= ~rdata;
        if (rst) begin
            cnt <= 0;
            terr <= 1'b0;
            rdata <= 8'h00;
        end else if (req && !done) begin
            if (op != 2'h3 && !osc_en) terr <= 1'b1;
            cnt <= cnt + 1;
            if (cnt == LAT) begin
                cnt <= 0;
                done <= 1'b1;
                if (op == 2'h0) mem[blk][addr[7:0]] <= wdata;
                if (op == 2'h3) rdata <= mem[blk][addr[7:0]];
            end
        end
    end
endmodule

// ==== flash_iap_mailbox_control_tb.sv ====
// self-checking bench of the flash programming mailbox front end
`timescale 1ns/10ps
module flash_iap_mailbox_control_tb;
    localparam logic [7:0] MFR = 8'h3c; // arbitrary value
    localparam logic [7:0] DEV = 8'hc3; // arbitrary value
    localparam logic [7:0] A_ST = iap_pkg::OFS_STATUS;
    localparam logic [7:0] A_IS = iap_pkg::OFS_IRQ_STATUS;
    logic clk, rst, psel, pen, pwr, pready, slverr, ean, ext_interrupt_one, fdone, req;
    logic fblk, osc, eclk, i1req, irq, terr;
    logic [7:0] pa, pd, frd, fwd, ah, al, d, vah, val, vd;
    logic [1:0] src, lock, fop, bbusy;
    logic [31:0] prd;
    logic [15:0] fad, e;
    logic [8:0] x;
    logic [8:0] q[$];
    logic [15:0] tbl [7] = '{16'h0803, 16'h1802, 16'h2873, 16'h2c03,
                             16'h2402, 16'h0a00, 16'h3800};
    int n_errors = 0, n_tests = 0, i;
    flash_iap_mailbox_control #(.MFR_ID(MFR), .DEV_ID(DEV), .SETTLE_CYC(2))
    i_flash_iap_mailbox_control (.SYS_CLK(clk), .SYS_RST(rst),
        .CLK_EN(1'b1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA({24'h00_0000, pd}), .PRDATA(prd),
        .PREADY(pready), .PSLVERR(slverr), .EXT_ACCESS_N(ean),
        .FETCH_SRC(src), .BLOCK_LOCK(lock), .EXT_INTERRUPT_ONE_PIN(ext_interrupt_one),
        .FL_DONE(fdone), .FL_RDATA(frd), .FL_REQ(req), .FL_OP(fop),
        .FL_BLOCK(fblk), .FL_ADDR(fad), .FL_WDATA(fwd), .OSC_EN(osc),
        .EXT_CLK_SEL(eclk), .BLOCK_BUSY(bbusy), .EXT_INTERRUPT_ONE_REQ(i1req),
        .IRQ(irq));
    flash_array_model i_flash_array_model (.clk(clk), .rst(rst),
        .req(req), .op(fop), .blk(fblk), .addr(fad), .wdata(fwd),
        .osc_en(osc), .done(fdone), .rdata(frd), .terr(terr));
    task automatic results;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic waitfor(ref logic s, input logic v);
        for (int k = 0; k < 300 && s !== v; k++) @(posedge clk);
        if (s !== v) begin
            n_errors++;
            results();
        end
    endtask
    // pready is tested before this edge's updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] dt);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= dt;
        @(posedge clk) pen <= 1'b1;
        waitfor(pready, 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] exp);
        q.push_back(exp);
        apb(1'b0, a, 8'h00);
    endtask
    task automatic op(input logic [7:0] h, l, dt, cm);
        apb(1'b1, iap_pkg::OFS_ADDR_LOW, l);
        apb(1'b1, iap_pkg::OFS_ADDR_HIGH, h);
        apb(1'b1, iap_pkg::OFS_DATA, dt);
        apb(1'b1, iap_pkg::OFS_CMD, cm);
    endtask
    always @(posedge clk) begin
        if (psel && pen && pready && !pwr) begin
            x = q.pop_front();
            chk({slverr, prd}, {x[8], 24'h00_0000, x[7:0]});
        end
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {psel, pen, pwr, pa, pd, src, lock, ext_interrupt_one} = '0;
        ean = 1'b1;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(34135));
        rd(A_ST, 9'h000);
        rd(8'h20, 9'h100);
        op(8'h00, 8'h30, 8'h77, {1'b0, iap_pkg::CMD_BYTE_PROG});
        chk({osc, req, bbusy, eclk}, 5'h00);
        rd(iap_pkg::OFS_DATA, 9'h077);
        chk(irq, 1'b0); // masked event keeps the line low
        apb(1'b1, iap_pkg::OFS_IRQ_MASK, 8'h03);
        waitfor(irq, 1'b1);
        rd(A_IS, 9'h002);
        waitfor(irq, 1'b0);
        apb(1'b1, iap_pkg::OFS_CONFIG, 8'h40);
        rd(iap_pkg::OFS_CONFIG, 9'h040);
        chk(eclk, 1'b1);
        for (i = 0; i < 2; i++) begin
            op(8'h00, 8'h30 + 8'(i), 8'h00, {1'b0, iap_pkg::CMD_READ_SIG});
            rd(iap_pkg::OFS_DATA, {1'b0, i ? DEV : MFR});
        end
        for (i = 0; i < 7; i++) begin
            e = tbl[i];
            ah = {e[6:4], 5'($urandom)};
            al = 8'($urandom);
            d = 8'($urandom);
            if (i == 0) {vah, val, vd} = {ah, al, d};
            src <= e[13:12];
            ean <= e[11];
            lock <= e[9:8];
            apb(1'b1, iap_pkg::OFS_CONFIG, {7'h20, e[10]});
            op(ah, al, d, {1'b0, iap_pkg::CMD_BYTE_PROG});
            if (e[1]) begin
                waitfor(osc, 1'b1);
                rd(A_ST, 9'h004);
                waitfor(req, 1'b1);
                chk({fblk, fop, fad, fwd, bbusy}, {e[0], 2'h0, ah, al, d,
                    e[0], !e[0]});
                waitfor(req, 1'b0);
                chk(osc, 1'b0);
                rd(A_IS, 9'h001);
            end else begin
                chk({osc, req, bbusy}, 4'h0);
                rd(A_IS, 9'h002);
            end
            rd(A_ST, 9'h000);
        end
        ext_interrupt_one <= 1'b1;
        src <= 2'h0;
        waitfor(i1req, 1'b1);
        op(8'h00, al, vd, {1'b1, iap_pkg::CMD_BYTE_PROG});
        waitfor(req, 1'b1);
        chk(i1req, 1'b0);
        ext_interrupt_one <= 1'b0;
        waitfor(req, 1'b0);
        waitfor(i1req, 1'b1);
        rd(A_IS, 9'h001);
        ext_interrupt_one <= 1'b0;
        src <= 2'h0;
        op(vah, val, 8'h00, {1'b0, iap_pkg::CMD_VERIFY});
        waitfor(req, 1'b1);
        chk({osc, fop}, 3'h3);
        waitfor(req, 1'b0);
        rd(iap_pkg::OFS_DATA, {1'b0, vd});
        chk(terr, 1'b0);
        results();
    end
endmodule
